// >>> common/eqs_pkg.sv
// Package with the constants, types and register map of the equalizer serial mode controller.
package eqs_pkg;

    // ------------------------------------------------------------
    // Register offsets (7-bit register address space)
    // ------------------------------------------------------------
    localparam logic [6:0] EQS_ADDR_PART_ID = 7'h00;
    localparam logic [6:0] EQS_ADDR_STATUS = 7'h01;
    localparam logic [6:0] EQS_ADDR_LENGTH = 7'h02;
    localparam logic [6:0] EQS_ADDR_EQ_CTRL = 7'h05;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int EQS_CTRL_MODE_LSB = 0;
    localparam int EQS_CTRL_COAX_BIT = 4;
    localparam int EQS_ADDR_RW_BIT = 7;
    localparam logic [7:0] EQS_LENGTH_RST = 8'h00;
    localparam logic [4:0] EQS_CTRL_RST = 5'h00;

    // ------------------------------------------------------------
    // Mode field codes
    // ------------------------------------------------------------
    localparam logic [1:0] EQS_MODE_CONT = 2'h0;
    localparam logic [1:0] EQS_MODE_LOSS = 2'h1;
    localparam logic [1:0] EQS_MODE_RESET = 2'h2;
    localparam logic [1:0] EQS_MODE_MANUAL = 2'h3;

    // ------------------------------------------------------------
    // Counts and timing
    // ------------------------------------------------------------
    localparam logic [3:0] EQS_BYTE_LAST = 4'h7;
    localparam logic [6:0] EQS_LINES_TO_LOCK = 7'h64;
    localparam logic [5:0] EQS_COAX_MAX_LEN = 6'h14;
    localparam int EQS_CLK_MHZ = 125;
    localparam int EQS_LOSS_TIME_US = 1000;
    localparam int EQS_LOSS_CYC = EQS_LOSS_TIME_US * EQS_CLK_MHZ;
    localparam int EQS_LOSS_W = 24;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EQS_PH_ADDR,
        EQS_PH_WRITE,
        EQS_PH_READ,
        EQS_PH_DONE
    } eqs_phase_e;

    typedef struct packed {
        logic settled;
        logic overloaded;
        logic color;
        logic nominal_pol;
        logic dll_locked;
        logic present;
    } eqs_status_s;

    typedef struct packed {
        logic freeze;
        logic restart;
        logic manual;
        logic coax;
        logic [5:0] length;
        logic invert;
        logic auto_polarity;
        logic locked;
    } eqs_eq_ctrl_s;

endpackage : eqs_pkg

// >>> design/eqs_serial_mode_ctrl.sv
// Three-wire serial register port and equalization mode controller.
`timescale 1ns/1ps

module eqs_serial_mode_ctrl
    import eqs_pkg::*;
#(
    parameter int unsigned LOSS_CYCLES = EQS_LOSS_CYC,
    parameter logic [3:0] PART_CODE = 4'h9,  // Arbitrary value.
    parameter logic [3:0] SILICON_REV = 4'h0  // Arbitrary value.
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic serial_select,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    input wire logic invert_pin,
    input wire eqs_status_s eq_status,
    input wire logic line_strobe,
    input wire logic eq_changed,
    output eqs_eq_ctrl_s eq_ctrl
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic sck_m;
        logic sck_s;
        logic sck_d;
        logic sel_m;
        logic sel_s;
        logic dl_m;
        logic dl_s;
        logic inv_m;
        logic inv_s;
        eqs_phase_e phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [6:0] addr;
        logic [7:0] rd_shift;
        logic dl_out;
        logic dl_oe;
        logic [7:0] length;
        logic [4:0] ctrl;
        logic restart;
        logic locked;
        logic [6:0] lines;
        logic [EQS_LOSS_W-1:0] loss_cnt;
        logic loss_long;
    } eqs_state_s;

    eqs_state_s q;
    eqs_state_s n;
    logic sck_rise;
    logic [7:0] in_byte;
    logic wr_fire;
    logic [1:0] mode;
    logic freeze_now;

    assign sck_rise = q.sck_s & ~q.sck_d;
    assign in_byte = {q.shift[6:0], q.dl_s};
    assign mode = q.ctrl[EQS_CTRL_MODE_LSB +: 2];
    assign freeze_now = q.locked & (mode == EQS_MODE_RESET | mode == EQS_MODE_LOSS);

    // Register read mux; unmapped addresses read as zero.
    function automatic logic [7:0] read_reg(input logic [6:0] a, input eqs_state_s s,
                                            input eqs_status_s st);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            EQS_ADDR_PART_ID: v = {PART_CODE, SILICON_REV};
            EQS_ADDR_STATUS: v = {2'h0, st};
            EQS_ADDR_LENGTH: v = s.length;
            EQS_ADDR_EQ_CTRL: v = {3'h0, s.ctrl};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Pins pass two flops; the second stage feeds the logic, and sck adds a third flop for edge detection.
    always_comb begin
        n = q;
        wr_fire = 1'b0;
        n.restart = 1'b0;
        n.sck_m = sck;
        n.sck_s = q.sck_m;
        n.sck_d = q.sck_s;
        n.sel_m = serial_select;
        n.sel_s = q.sel_m;
        n.dl_m = serial_data_line_in;
        n.dl_s = q.dl_m;
        n.inv_m = invert_pin;
        n.inv_s = q.inv_m;

        // Serial frame engine. Clocks past the sixteenth are ignored.
        if (!q.sel_s) begin
            n.phase = EQS_PH_ADDR;
            n.bit_cnt = 4'h0;
            n.dl_oe = 1'b0;
        end else if (sck_rise) begin
            n.bit_cnt = q.bit_cnt + 4'h1;
            unique case (q.phase)
                EQS_PH_ADDR: begin
                    n.shift = in_byte;
                    if (q.bit_cnt == EQS_BYTE_LAST) begin
                        n.bit_cnt = 4'h0;
                        n.addr = in_byte[6:0];
                        n.rd_shift = read_reg(in_byte[6:0], q, eq_status);
                        n.phase = in_byte[EQS_ADDR_RW_BIT] ? EQS_PH_READ : EQS_PH_WRITE;
                    end
                end
                EQS_PH_WRITE: begin
                    n.shift = in_byte;
                    if (q.bit_cnt == EQS_BYTE_LAST) begin
                        n.phase = EQS_PH_DONE;
                        wr_fire = 1'b1;
                    end
                end
                EQS_PH_READ: begin
                    n.dl_oe = 1'b1;
                    n.dl_out = q.rd_shift[7];
                    n.rd_shift = {q.rd_shift[6:0], 1'b0};
                    if (q.bit_cnt == EQS_BYTE_LAST) begin
                        n.phase = EQS_PH_DONE;
                    end
                end
                EQS_PH_DONE: begin
                    n.bit_cnt = q.bit_cnt;
                end
            endcase
        end

        // Register writes. Reserved control bits are dropped on purpose.
        if (wr_fire) begin
            if (q.addr == EQS_ADDR_LENGTH) begin
                n.length = in_byte;
            end
            if (q.addr == EQS_ADDR_EQ_CTRL) begin
                n.ctrl = in_byte[4:0];
                // Only software can restart the reset-lock mode; polarity
                // changes never reach this term.
                if (in_byte[1:0] == EQS_MODE_RESET && mode == EQS_MODE_CONT) begin
                    n.restart = 1'b1;
                end
            end
        end

        // Signal loss timer: only a long absence arms a restart on return.
        n.loss_cnt = '0;
        if (mode == EQS_MODE_LOSS) begin
            if (!eq_status.present) begin
                n.loss_cnt = q.loss_cnt;
                if (q.loss_cnt == LOSS_CYCLES[EQS_LOSS_W-1:0]) begin
                    n.loss_long = 1'b1;
                end else begin
                    n.loss_cnt = q.loss_cnt + 1'b1;
                end
            end else if (q.loss_long) begin
                n.loss_long = 1'b0;
                n.restart = 1'b1;
            end
        end else begin
            n.loss_long = 1'b0;
        end

        // Lock tracking. Once frozen, adaptation changes are not counted.
        if (n.restart || (eq_changed && !freeze_now)) begin
            n.locked = 1'b0;
            n.lines = 7'h00;
        end else if (!q.locked && line_strobe) begin
            n.lines = q.lines + 7'h01;
            if (q.lines == EQS_LINES_TO_LOCK - 7'h01) begin
                n.locked = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            q <= '0;
            q.length <= EQS_LENGTH_RST;
            q.ctrl <= EQS_CTRL_RST;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Coax lengths clamp so codes past the last useful step add nothing.
    always_comb begin
        eq_ctrl.manual = (mode == EQS_MODE_MANUAL);
        eq_ctrl.freeze = freeze_now;
        eq_ctrl.restart = q.restart;
        eq_ctrl.locked = q.locked;
        eq_ctrl.coax = eq_ctrl.manual & q.ctrl[EQS_CTRL_COAX_BIT];
        eq_ctrl.length = q.length[5:0];
        if (eq_ctrl.coax && q.length[5:0] > EQS_COAX_MAX_LEN) begin
            eq_ctrl.length = EQS_COAX_MAX_LEN;
        end
        eq_ctrl.auto_polarity = ~eq_ctrl.manual;
        eq_ctrl.invert = eq_ctrl.manual ? q.inv_s : ~eq_status.nominal_pol;
    end

    assign serial_data_line_out = q.dl_out;
    assign serial_data_line_oe = q.dl_oe;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    property p_release_on_deselect;
        !q.sel_s |=> !serial_data_line_oe ##1 !serial_data_line_oe;
    endproperty
    a_release_on_deselect: assert property (p_release_on_deselect)
        else $error("data line still driven after deselect");

    property p_drive_ninth_edge;
        (q.sel_s && sck_rise && q.phase == EQS_PH_READ && q.bit_cnt == 4'h0)
            |=> serial_data_line_oe && serial_data_line_out == $past(q.rd_shift[7]);
    endproperty
    a_drive_ninth_edge: assert property (p_drive_ninth_edge)
        else $error("read data not driven at ninth edge");

    property p_no_drive_in_address;
        q.phase == EQS_PH_ADDR |-> !serial_data_line_oe;
    endproperty
    a_no_drive_in_address: assert property (p_no_drive_in_address)
        else $error("data line driven during address byte");

    property p_restart_sequence;
        (wr_fire && q.addr == EQS_ADDR_EQ_CTRL && mode == EQS_MODE_CONT
            && in_byte[1:0] == EQS_MODE_RESET) |=> eq_ctrl.restart ##1 !eq_ctrl.locked;
    endproperty
    a_restart_sequence: assert property (p_restart_sequence)
        else $error("continuous then reset-lock write did not restart");

    property p_no_polarity_restart;
        (mode == EQS_MODE_RESET && !wr_fire) |=> !eq_ctrl.restart;
    endproperty
    a_no_polarity_restart: assert property (p_no_polarity_restart)
        else $error("restart in reset-lock mode without software write");

    property p_freeze_locked;
        (eq_ctrl.locked && (q.ctrl[1] ^ q.ctrl[0])) |-> eq_ctrl.freeze && !eq_ctrl.manual;
    endproperty
    a_freeze_locked: assert property (p_freeze_locked)
        else $error("locked lock mode not frozen");

    property p_hold_lock;
        (freeze_now && !n.restart) |=> q.locked;
    endproperty
    a_hold_lock: assert property (p_hold_lock)
        else $error("frozen lock dropped without restart");

    property p_loss_return;
        (mode == EQS_MODE_LOSS && q.loss_long && eq_status.present) |=> eq_ctrl.restart;
    endproperty
    a_loss_return: assert property (p_loss_return)
        else $error("long signal loss did not re-equalize");

    property p_lock_after_lines;
        $rose(q.locked) |-> $past(line_strobe) && $past(q.lines) == EQS_LINES_TO_LOCK - 7'h01;
    endproperty
    a_lock_after_lines: assert property (p_lock_after_lines)
        else $error("lock raised before line count reached");

    property p_coax_clamp;
        eq_ctrl.coax |-> eq_ctrl.length <= EQS_COAX_MAX_LEN
            && (eq_ctrl.length == EQS_COAX_MAX_LEN || eq_ctrl.length == q.length[5:0]);
    endproperty
    a_coax_clamp: assert property (p_coax_clamp)
        else $error("coax length above clamp");

    property p_manual_polarity;
        eq_ctrl.manual |-> !eq_ctrl.auto_polarity && eq_ctrl.invert == q.inv_s;
    endproperty
    a_manual_polarity: assert property (p_manual_polarity)
        else $error("manual mode polarity not from pin");

    property p_cov_read;
        q.phase == EQS_PH_READ ##1 q.phase == EQS_PH_DONE;
    endproperty
    c_cov_read: cover property (p_cov_read);

    property p_cov_write_ctrl;
        wr_fire && q.addr == EQS_ADDR_EQ_CTRL;
    endproperty
    c_cov_write_ctrl: cover property (p_cov_write_ctrl);

    property p_cov_lock;
        $rose(q.locked);
    endproperty
    c_cov_lock: cover property (p_cov_lock);

    property p_cov_loss_restart;
        mode == EQS_MODE_LOSS && $rose(eq_ctrl.restart);
    endproperty
    c_cov_loss_restart: cover property (p_cov_loss_restart);

endmodule : eqs_serial_mode_ctrl

// >>> tb/eqs_host_model.sv
// Host controller model that drives the three-wire serial register port.
`timescale 1ns/1ps

module eqs_host_model (
    input wire logic core_clk,
    output logic sck,
    output logic serial_select,
    output logic line_to_dut,
    input wire logic dut_out,
    input wire logic dut_oe
);
    logic host_oe;
    logic host_bit;
    logic idle_val;

    // ------------------------------------------------------------
    // Shared data line
    // ------------------------------------------------------------
    // With no pull on the wire, a released line shows the inverse of its last value.
    assign line_to_dut = dut_oe ? dut_out : (host_oe ? host_bit : idle_val);

    // Remember what the device drove last, so stale data is never read as valid.
    always @(posedge core_clk) begin
        if (dut_oe) begin
            idle_val <= ~dut_out;
        end
    end

    // The freeze pin is not modelled.
    initial begin
        sck = 1'b0;
        serial_select = 1'b0;
        host_oe = 1'b0;
        host_bit = 1'b0;
        idle_val = 1'b1;
    end

    // ------------------------------------------------------------
    // One frame: address byte then data byte, cut short when nbits is below 16
    // ------------------------------------------------------------
    // Clock is low 24 ns and high 40 ns, a 64 ns period of about 15.6 MHz.
    // Data changes only on falling edges, so the device never samples a moving bit.
    task automatic frame(input logic [15:0] bits, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        serial_select = 1'b1;
        host_oe = 1'b1;
        #24;
        for (int i = 0; i < nbits; i++) begin
            if (host_oe) begin
                host_bit = bits[15 - i];
            end
            #24;
            sck = 1'b1;
            #40;
            sck = 1'b0;
            if (bits[15] && i >= 8) begin
                rd[15 - i] = line_to_dut;
            end
            if (bits[15] && i == 7) begin
                host_oe = 1'b0;
                idle_val = ~host_bit;
            end
        end
        #24;
        serial_select = 1'b0;
        if (host_oe) begin
            idle_val = ~host_bit;
        end
        host_oe = 1'b0;
        #64;
    endtask : frame

endmodule : eqs_host_model

// >>> tb/tb_top.sv
// Self-checking testbench of the equalizer serial mode controller.
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("[ERR] %s expected %h seen %h", nm, exp, got); \
        end \
    end

module tb_top
    import eqs_pkg::*;
();
    logic core_clk;
    logic rst_n;
    logic sck;
    logic serial_select;
    logic line;
    logic dout;
    logic doe;
    logic invert_pin;
    eqs_status_s eq_status;
    logic line_strobe;
    logic eq_changed;
    eqs_eq_ctrl_s eq_ctrl;
    int err_total = 0;
    int check_count = 0;
    int restart_cnt = 0;

    // ------------------------------------------------------------
    // Design, host and clock
    // ------------------------------------------------------------
    // Loss time is cut to 50 cycles; identity values are arbitrary.
    eqs_serial_mode_ctrl #(.LOSS_CYCLES(50), .PART_CODE(4'h6), .SILICON_REV(4'h1)) i_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sck(sck),
        .serial_select(serial_select),
        .serial_data_line_in(line),
        .serial_data_line_out(dout),
        .serial_data_line_oe(doe),
        .invert_pin(invert_pin),
        .eq_status(eq_status),
        .line_strobe(line_strobe),
        .eq_changed(eq_changed),
        .eq_ctrl(eq_ctrl)
    );

    eqs_host_model i_host (
        .core_clk(core_clk),
        .sck(sck),
        .serial_select(serial_select),
        .line_to_dut(line),
        .dut_out(dout),
        .dut_oe(doe)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Restart is a single-cycle pulse, so count every one seen.
    always @(posedge core_clk) begin
        if (rst_n && eq_ctrl.restart === 1'b1) begin
            restart_cnt <= restart_cnt + 1;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        i_host.frame({1'b0, a, d}, 16, unused);
    endtask : wr

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] got;
        i_host.frame({1'b1, a, 8'h00}, 16, got);
        `CHK(nm, exp, got)
        `CHK("oe after frame", 1'b0, doe)
    endtask : rd_chk

    // Lines are spaced one idle cycle apart.
    task automatic strobes(input int n);
        repeat (n) begin
            @(posedge core_clk) line_strobe <= 1'b1;
            @(posedge core_clk) line_strobe <= 1'b0;
        end
        repeat (2) @(posedge core_clk);
        #1;
    endtask : strobes

    task automatic pulse_change();
        @(posedge core_clk) eq_changed <= 1'b1;
        @(posedge core_clk) eq_changed <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask : pulse_change

    // Signal absence of n cycles, then a fixed window to catch any restart.
    task automatic absent(input int n);
        @(posedge core_clk) eq_status.present <= 1'b0;
        repeat (n) @(posedge core_clk);
        eq_status.present <= 1'b1;
        repeat (12) @(posedge core_clk);
        #1;
    endtask : absent

    // A hang anywhere is cut short here.
    initial begin
        #400000;
        err_total++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        invert_pin = 1'b1;
        eq_status = 6'h2d;
        line_strobe = 1'b0;
        eq_changed = 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        `CHK("locked rst", 1'b0, eq_ctrl.locked)
        `CHK("auto pol rst", 1'b1, eq_ctrl.auto_polarity)
        `CHK("invert auto", 1'b0, eq_ctrl.invert)
        rd_chk(EQS_ADDR_PART_ID, 8'h61, "identity");
        rd_chk(EQS_ADDR_STATUS, 8'h2d, "status a");
        eq_status <= 6'h12;
        rd_chk(EQS_ADDR_STATUS, 8'h12, "status b");
        eq_status <= 6'h2d;
        rd_chk(EQS_ADDR_LENGTH, 8'h00, "length rst");
        rd_chk(EQS_ADDR_EQ_CTRL, 8'h00, "ctrl rst");
        rd_chk(7'h07, 8'h00, "unmapped");
        // Every mode code; none of these steps is the restart sequence.
        for (int m = 0; m < 4; m++) begin
            wr(EQS_ADDR_EQ_CTRL, 8'(m));
            rd_chk(EQS_ADDR_EQ_CTRL, 8'(m), "mode");
            `CHK("manual flag", (m == 3), eq_ctrl.manual)
        end
        `CHK("no restart", 0, restart_cnt)
        // Continuous mode: 99 quiet lines are one too few.
        wr(EQS_ADDR_EQ_CTRL, 8'h00);
        strobes(99);
        `CHK("lock 99", 1'b0, eq_ctrl.locked)
        strobes(1);
        `CHK("lock 100", 1'b1, eq_ctrl.locked)
        pulse_change();
        `CHK("unlock", 1'b0, eq_ctrl.locked)
        // Length register, read-only writes and an aborted write.
        wr(EQS_ADDR_LENGTH, 8'h3f);
        rd_chk(EQS_ADDR_LENGTH, 8'h3f, "length");
        wr(EQS_ADDR_PART_ID, 8'hff);
        rd_chk(EQS_ADDR_PART_ID, 8'h61, "id ro");
        begin
            logic [7:0] unused;
            i_host.frame({1'b0, EQS_ADDR_LENGTH, 8'h55}, 12, unused);
        end
        rd_chk(EQS_ADDR_LENGTH, 8'h3f, "aborted");
        // Manual mode, spare control bits written high.
        wr(EQS_ADDR_EQ_CTRL, 8'he3);
        rd_chk(EQS_ADDR_EQ_CTRL, 8'h03, "ctrl bits");
        `CHK("auto pol man", 1'b0, eq_ctrl.auto_polarity)
        `CHK("invert man", 1'b1, eq_ctrl.invert)
        `CHK("len cat", 6'h3f, eq_ctrl.length)
        wr(EQS_ADDR_EQ_CTRL, 8'h13);
        `CHK("coax", 1'b1, eq_ctrl.coax)
        `CHK("len coax", 6'h14, eq_ctrl.length)
        wr(EQS_ADDR_LENGTH, 8'h13);
        `CHK("len coax low", 6'h13, eq_ctrl.length)
        // Reset-lock: lock holds through changes and polarity toggles.
        wr(EQS_ADDR_EQ_CTRL, 8'h02);
        strobes(100);
        pulse_change();
        `CHK("frozen", 1'b1, eq_ctrl.locked)
        `CHK("freeze", 1'b1, eq_ctrl.freeze)
        @(posedge core_clk) invert_pin <= 1'b0;
        repeat (20) @(posedge core_clk);
        `CHK("toggle", 0, restart_cnt)
        rd_chk(EQS_ADDR_STATUS, 8'h2d, "status pin");
        wr(EQS_ADDR_EQ_CTRL, 8'h00);
        wr(EQS_ADDR_EQ_CTRL, 8'h02);
        `CHK("sw restart", 1, restart_cnt)
        `CHK("relock", 1'b0, eq_ctrl.locked)
        // Loss-lock: short absence ignored, long absence re-equalizes.
        wr(EQS_ADDR_EQ_CTRL, 8'h01);
        strobes(100);
        pulse_change();
        `CHK("loss frozen", 1'b1, eq_ctrl.locked)
        `CHK("loss freeze", 1'b1, eq_ctrl.freeze)
        absent(20);
        `CHK("short loss", 1, restart_cnt)
        `CHK("still locked", 1'b1, eq_ctrl.locked)
        absent(60);
        `CHK("long loss", 2, restart_cnt)
        `CHK("loss unlock", 1'b0, eq_ctrl.locked)
        complete_run();
    end

endmodule : tb_top
